// ===== fpm_pkg.sv
// fpm_pkg.sv
// holds register offsets, field positions, reset values and enums for the fault pin block
// assumes a 32-bit classic wishbone slave with word-aligned registers
package fpm_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int unsigned NUM_CHAN = 4;
	localparam int unsigned ADDR_W = 8;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_MASK = 8'h00;       // fault pin mask register
	localparam logic [7:0] OFS_MODE = 8'h04;       // per-channel mode, two bits each
	localparam logic [7:0] OFS_OWEN = 8'h08;       // openwire_enable_reg: detect and gate enables
	localparam logic [7:0] OFS_OWFLAG = 8'h0c;     // openwire_flag_reg, write one to clear
	localparam logic [7:0] OFS_OVLFLAG = 8'h10;    // overload_flag_reg, write one to clear
	localparam logic [7:0] OFS_INTR = 8'h14;       // comm and supply flags, write one to clear
	localparam logic [7:0] OFS_STATUS = 8'h18;     // frame status bits and fault pin, read only
	localparam logic [7:0] OFS_OUTSET = 8'h1c;     // serial output states

	// ------------------------------------------------------------
	// mask register bit positions
	// ------------------------------------------------------------
	localparam int unsigned MB_CURR_LIMIT = 1;
	localparam int unsigned MB_OPENWIRE = 2;
	localparam int unsigned MB_ABOVE_SUPPLY = 3;
	localparam int unsigned MB_THERMAL = 4;
	localparam int unsigned MB_SUPPLY_ERR = 6;
	localparam int unsigned MB_COMM_ERR = 7;

	// ------------------------------------------------------------
	// status register bit positions
	// ------------------------------------------------------------
	localparam int unsigned SB_OPENWIRE = 0;
	localparam int unsigned SB_OVERCURR = 1;
	localparam int unsigned SB_THERMAL = 2;
	localparam int unsigned SB_GLOBAL = 3;
	localparam int unsigned SB_FAULT_PIN = 4;

	// ------------------------------------------------------------
	// field offsets in flag and enable registers
	// ------------------------------------------------------------
	localparam int unsigned FO_CL = 0;       // current limit flags in overload reg
	localparam int unsigned FO_OVL = 4;      // thermal flags in overload reg
	localparam int unsigned FO_OWDET = 0;    // open-wire detect enables
	localparam int unsigned FO_GDRV = 4;     // gate drive enables
	localparam int unsigned IB_COMM = 0;     // comm error flag in intr reg
	localparam int unsigned IB_SUPPLY = 1;   // supply error flag in intr reg

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;     // all channels high-side output
	localparam logic [7:0] RST_OWEN = 8'h00;
	localparam logic [3:0] RST_OUTSET = 4'h0;

	// channel modes
	typedef enum logic [1:0] {
		FPM_MODE_HIGHSIDE,
		FPM_MODE_PUSHPULL,
		FPM_MODE_INPUT,
		FPM_MODE_INPUT_HIZ
	} fpm_mode_e;

endpackage

// ===== fpm_chan.sv
// fpm_chan.sv
// holds one channel's sticky fault flags, output switch and gate drive
// assumes fault inputs are synchronous to CORE_CLK and clears come from the bus slave
`timescale 1ns/1ps
`default_nettype none
module fpm_chan
	import fpm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// configuration
	input wire logic [1:0] mode,
	input wire logic ow_det_en,
	input wire logic gdrv_en,
	input wire logic ser_ctrl,
	input wire logic ser_out,
	input wire logic pin_data,
	input wire logic pin_en,
	input wire logic pin_sync,
	// raw fault events
	input wire logic ev_openwire,
	input wire logic ev_curr_limit,
	input wire logic ev_thermal,
	// clears, one-cycle write strobes
	input wire logic clr_openwire,
	input wire logic clr_curr_limit,
	input wire logic clr_thermal,
	// results
	output logic flag_openwire,
	output logic flag_curr_limit,
	output logic flag_thermal,
	output logic switch_on,
	output logic gate_on
);

	// ------------------------------------------------------------
	// sticky flags and drivers
	// ------------------------------------------------------------
	logic ow_q, ow_d;     // open-wire flag
	logic cl_q, cl_d;     // current-limit flag
	logic ovl_q, ovl_d;   // thermal flag
	logic sw_q, sw_d;     // output switch
	logic g_q, g_d;       // reverse-protection gate
	logic is_output;      // channel in an output mode

	// next-state logic; set wins over clear
	always_comb begin
		is_output = (mode == FPM_MODE_HIGHSIDE) || (mode == FPM_MODE_PUSHPULL);
		ow_d = (ow_q && !clr_openwire) || (ev_openwire && ow_det_en);
		cl_d = (cl_q && !clr_curr_limit) || ev_curr_limit;
		ovl_d = (ovl_q && !clr_thermal) || ev_thermal;
		// pin control at default mode needs data, enable and sync all high
		if (ser_ctrl) begin
			sw_d = is_output && ser_out;
		end else begin
			sw_d = is_output && pin_data && pin_en && pin_sync;
		end
		g_d = is_output && gdrv_en;
	end

	// registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ow_q <= 1'b0;
			cl_q <= 1'b0;
			ovl_q <= 1'b0;
			sw_q <= 1'b0;
			g_q <= 1'b0;
		end else if (ce) begin
			ow_q <= ow_d;
			cl_q <= cl_d;
			ovl_q <= ovl_d;
			sw_q <= sw_d;
			g_q <= g_d;
		end
	end

	assign flag_openwire = ow_q;
	assign flag_curr_limit = cl_q;
	assign flag_thermal = ovl_q;
	assign switch_on = sw_q;
	assign gate_on = g_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_gate_input_off: assert property (@(posedge clk) disable iff (!rst_n)
		ce && $past(ce) && !mode[1] == 1'b0 && $past(mode[1]) |-> !gate_on)
		else $error("gate on while channel in input mode");

	chk_pin_switch_on: assert property (@(posedge clk) disable iff (!rst_n)
		ce && !ser_ctrl && mode == FPM_MODE_HIGHSIDE && pin_data && pin_en && pin_sync
		|=> !ce || switch_on)
		else $error("switch stayed off with all control pins high");

	chk_limit_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
		ce && ev_curr_limit |=> flag_curr_limit)
		else $error("current-limit flag not set");

	chk_thermal_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
		ce && ev_thermal |=> flag_thermal)
		else $error("thermal flag not set");

	chk_openwire_flag: assert property (@(posedge clk) disable iff (!rst_n)
		ce && ev_openwire && ow_det_en |=> flag_openwire)
		else $error("open-wire flag not set");

endmodule
`default_nettype wire

// ===== fpm_top.sv
// fpm_top.sv
// holds the fault pin masking, flag registers and power-up defaults of a four-channel output/input
// assumes a classic wishbone master on CORE_CLK, fault events synchronous to CORE_CLK
`timescale 1ns/1ps
`default_nettype none
module fpm_top
	import fpm_pkg::*;
(
	// clock, reset, enable
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic CE,
	// wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [ADDR_W-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// direct control pins
	input wire logic SER_CTRL,
	input wire logic [NUM_CHAN-1:0] CHANNEL_DATA,
	input wire logic ENABLE_IN,
	input wire logic SYNC_UPDATE_INPUT,
	// fault events from the analog side
	input wire logic [NUM_CHAN-1:0] EV_OPENWIRE,
	input wire logic [NUM_CHAN-1:0] EV_CURR_LIMIT,
	input wire logic [NUM_CHAN-1:0] EV_THERMAL,
	input wire logic [NUM_CHAN-1:0] EV_ABOVE_SUPPLY,
	input wire logic EV_COMM_ERR,
	input wire logic EV_SUPPLY_ERR,
	// channel drive
	output logic [NUM_CHAN-1:0] CHANNEL_SWITCH_ON,
	output logic [NUM_CHAN-1:0] GATE_DRIVE_ON,
	// frame status bits
	output logic FRAME_OPENWIRE_STATUS,
	output logic FRAME_OVERCURRENT_STATUS,
	output logic FRAME_THERMAL_STATUS,
	output logic FRAME_GLOBAL_FAULT,
	// open-drain fault pin, low enable drives it low
	output logic FAULT_O,
	output logic FAULT_OE_N
);

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	logic [7:0] mask_q, mask_d;       // fault pin masks
	logic [7:0] mode_q, mode_d;       // channel modes
	logic [7:0] owen_q, owen_d;       // openwire_enable_reg
	logic [3:0] outset_q, outset_d;   // serial output states
	logic [3:0] above_q, above_d;     // above-supply sticky flags
	logic comm_q, comm_d;             // comm error flag
	logic supply_q, supply_d;         // supply error flag
	logic ack_q, ack_d;               // bus answer
	logic [31:0] rdat_q, rdat_d;      // read data
	logic fault_q, fault_d;           // fault pin state

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic req;                        // new request this cycle
	logic wr;                         // write taken this cycle
	logic [31:0] wmask;               // byte-lane mask
	logic [31:0] wv;                  // masked write data
	logic [NUM_CHAN-1:0] clr_ow, clr_cl, clr_ovl;
	logic [NUM_CHAN-1:0] f_ow, f_cl, f_ovl;
	logic active_ow, active_cl, active_ovl, active_above;

	// one request answered per cycle pair; ack drops the cycle after
	assign req = WB_CYC_I && WB_STB_I && !ack_q;
	assign wr = req && WB_WE_I;

	// byte lanes
	always_comb begin
		wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
		wv = WB_DAT_I & wmask;
		clr_ow = '0;
		clr_cl = '0;
		clr_ovl = '0;
		// write-one-to-clear strobes
		if (wr && WB_ADR_I == OFS_OWFLAG) begin
			clr_ow = wv[NUM_CHAN-1:0];
		end
		if (wr && WB_ADR_I == OFS_OVLFLAG) begin
			clr_cl = wv[FO_CL +: NUM_CHAN];
			clr_ovl = wv[FO_OVL +: NUM_CHAN];
		end
	end

	// ------------------------------------------------------------
	// channels
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
			fpm_chan u_chan (
				.clk(CORE_CLK),
				.rst_n(RST_N),
				.ce(CE),
				.mode(mode_q[2*gi +: 2]),
				.ow_det_en(owen_q[FO_OWDET + gi]),
				.gdrv_en(owen_q[FO_GDRV + gi]),
				.ser_ctrl(SER_CTRL),
				.ser_out(outset_q[gi]),
				.pin_data(CHANNEL_DATA[gi]),
				.pin_en(ENABLE_IN),
				.pin_sync(SYNC_UPDATE_INPUT),
				.ev_openwire(EV_OPENWIRE[gi]),
				.ev_curr_limit(EV_CURR_LIMIT[gi]),
				.ev_thermal(EV_THERMAL[gi]),
				.clr_openwire(clr_ow[gi]),
				.clr_curr_limit(clr_cl[gi]),
				.clr_thermal(clr_ovl[gi]),
				.flag_openwire(f_ow[gi]),
				.flag_curr_limit(f_cl[gi]),
				.flag_thermal(f_ovl[gi]),
				.switch_on(CHANNEL_SWITCH_ON[gi]),
				.gate_on(GATE_DRIVE_ON[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// fault summary
	// ------------------------------------------------------------
	always_comb begin
		active_ow = |f_ow;
		active_cl = |f_cl;
		active_ovl = |f_ovl;
		active_above = |above_q;
	end

	// ------------------------------------------------------------
	// register next values
	// ------------------------------------------------------------
	always_comb begin
		mask_d = mask_q;
		mode_d = mode_q;
		owen_d = owen_q;
		outset_d = outset_q;
		// sticky flags, set wins over clear
		above_d = above_q | EV_ABOVE_SUPPLY;
		comm_d = comm_q | EV_COMM_ERR;
		supply_d = supply_q | EV_SUPPLY_ERR;
		if (wr) begin
			unique case (WB_ADR_I)
				OFS_MASK: mask_d = wv[7:0] | (mask_q & ~wmask[7:0]);
				OFS_MODE: mode_d = wv[7:0] | (mode_q & ~wmask[7:0]);
				OFS_OWEN: owen_d = wv[7:0] | (owen_q & ~wmask[7:0]);
				OFS_OUTSET: outset_d = wv[3:0] | (outset_q & ~wmask[3:0]);
				OFS_OWFLAG: above_d = (above_q & ~wv[FO_GDRV +: NUM_CHAN]) | EV_ABOVE_SUPPLY;
				OFS_INTR: begin
					comm_d = (comm_q && !wv[IB_COMM]) || EV_COMM_ERR;
					supply_d = (supply_q && !wv[IB_SUPPLY]) || EV_SUPPLY_ERR;
				end
				default: ;
			endcase
		end
		// answer every request in the next cycle, unmapped reads give zero
		ack_d = req;
		rdat_d = '0;
		if (req && !WB_WE_I) begin
			unique case (WB_ADR_I)
				OFS_MASK: rdat_d[7:0] = mask_q;
				OFS_MODE: rdat_d[7:0] = mode_q;
				OFS_OWEN: rdat_d[7:0] = owen_q;
				OFS_OWFLAG: rdat_d[7:0] = {above_q, f_ow};
				OFS_OVLFLAG: rdat_d[7:0] = {f_ovl, f_cl};
				OFS_INTR: rdat_d[1:0] = {supply_q, comm_q};
				OFS_STATUS: rdat_d[4:0] = {fault_q, FRAME_GLOBAL_FAULT,
					FRAME_THERMAL_STATUS, FRAME_OVERCURRENT_STATUS, FRAME_OPENWIRE_STATUS};
				OFS_OUTSET: rdat_d[3:0] = outset_q;
				default: rdat_d = '0;
			endcase
		end
		// pin follows any unmasked active class
		fault_d = (active_ow && !mask_q[MB_OPENWIRE])
			|| (active_cl && !mask_q[MB_CURR_LIMIT])
			|| (active_ovl && !mask_q[MB_THERMAL])
			|| (active_above && !mask_q[MB_ABOVE_SUPPLY])
			|| (comm_q && !mask_q[MB_COMM_ERR])
			|| (supply_q && !mask_q[MB_SUPPLY_ERR]);
	end

	// registers, reset gives high-side mode on every channel
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mask_q <= RST_MASK;
			mode_q <= RST_MODE;
			owen_q <= RST_OWEN;
			outset_q <= RST_OUTSET;
			above_q <= '0;
			comm_q <= 1'b0;
			supply_q <= 1'b0;
			ack_q <= 1'b0;
			rdat_q <= '0;
			fault_q <= 1'b0;
		end else if (CE) begin
			mask_q <= mask_d;
			mode_q <= mode_d;
			owen_q <= owen_d;
			outset_q <= outset_d;
			above_q <= above_d;
			comm_q <= comm_d;
			supply_q <= supply_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
			fault_q <= fault_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdat_q;
	assign FRAME_OPENWIRE_STATUS = active_ow;
	assign FRAME_OVERCURRENT_STATUS = active_cl;
	assign FRAME_THERMAL_STATUS = active_ovl;
	assign FRAME_GLOBAL_FAULT = active_ow || active_cl || active_ovl || active_above
		|| comm_q || supply_q;
	assign FAULT_O = 1'b0;
	assign FAULT_OE_N = !fault_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_comm_masked;
		mask_q[MB_COMM_ERR] && comm_q && !active_ow && !active_cl && !active_ovl
			&& !active_above && !supply_q && !(wr && WB_ADR_I == OFS_INTR && wv[IB_COMM]);
	endsequence

	chk_comm_masked_pin: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(CE and s_comm_masked) |=> !CE || (FAULT_OE_N && FRAME_GLOBAL_FAULT))
		else $error("masked comm error reached fault pin");

	chk_supply_flagged: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		CE && EV_SUPPLY_ERR |=> !CE || (supply_q && FRAME_GLOBAL_FAULT))
		else $error("supply error not flagged");

	chk_openwire_unmasked: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		CE && active_ow && !mask_q[MB_OPENWIRE] |=> !CE || !FAULT_OE_N)
		else $error("unmasked open wire did not pull fault pin");

	chk_limit_unmasked: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		CE && active_cl && !mask_q[MB_CURR_LIMIT] |=> !CE || !FAULT_OE_N)
		else $error("unmasked current limit did not pull fault pin");

	chk_thermal_unmasked: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		CE && active_ovl && !mask_q[MB_THERMAL] |=> !CE || !FAULT_OE_N)
		else $error("unmasked thermal did not pull fault pin");

	chk_pin_release: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		CE && $past(CE) && !FRAME_GLOBAL_FAULT && !$past(FRAME_GLOBAL_FAULT) |-> FAULT_OE_N)
		else $error("fault pin held with no active fault");

	chk_reset_mode: assert property (@(posedge CORE_CLK)
		!RST_N |-> mode_q == RST_MODE)
		else $error("channel mode not high-side at reset");

	chk_limit_frame: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		CE && EV_CURR_LIMIT != '0 |=> !CE || FRAME_OVERCURRENT_STATUS)
		else $error("overcurrent frame bit missing");

endmodule
`default_nettype wire

// ===== fpm_host_model.sv
// fpm_host_model.sv
// host side model: drives the direct control pins and pulls up the shared fault line
// assumes the bench gives the requested pin levels and sees the resolved fault line
`timescale 1ns/1ps
`default_nettype none
module fpm_host_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// requests from the bench
	input wire logic ser_req,
	input wire logic [3:0] data_req,
	input wire logic en_req,
	input wire logic sync_req,
	// device fault pin
	input wire logic fault_o,
	input wire logic fault_oe_n,
	// pins towards the device
	output logic ser_ctrl,
	output logic [3:0] chan_data,
	output logic enable_in,
	output logic sync_in,
	output logic fault_line
);
	// ------------------------------------------------------------
	// pin drivers
	// ------------------------------------------------------------
	// pins change just after the clock edge, held safe through power-up
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ser_ctrl <= 1'b1;
			chan_data <= 4'h0; // data low at power-up
			enable_in <= 1'b0; // one control pin low at power-up
			sync_in <= 1'b0;
		end else begin
			ser_ctrl <= ser_req;
			chan_data <= ser_req ? 4'h0 : data_req; // serial mode keeps data low
			enable_in <= en_req;
			sync_in <= sync_req;
		end
	end

	// ------------------------------------------------------------
	// fault line
	// ------------------------------------------------------------
	// pull-up: high unless the device enables its low drive
	assign fault_line = fault_oe_n ? 1'b1 : fault_o;
endmodule
`default_nettype wire

// ===== fpm_top_tb.sv
// fpm_top_tb.sv
// self-checking bench: wishbone tasks, reset values, pin control, gate drive, fault masking
// assumes fpm_pkg and fpm_host_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module fpm_top_tb import fpm_pkg::*;;
	// ------------------------------------------------------------
	// tables
	// ------------------------------------------------------------
	localparam logic [7:0] RST_OFS [9] = '{OFS_MASK, OFS_MODE, OFS_OWEN, OFS_OUTSET, OFS_OWFLAG,
		OFS_OVLFLAG, OFS_INTR, OFS_STATUS, 8'h20};
	localparam logic [31:0] RST_VAL [9] = '{{24'h0, RST_MASK}, {24'h0, RST_MODE}, {24'h0, RST_OWEN},
		{28'h0, RST_OUTSET}, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	// per class: flag register, flag bit base, mask bit, expected frame {glob,therm,oc,ow}
	localparam logic [7:0] CLS_OFS [6] = '{OFS_OWFLAG, OFS_OVLFLAG, OFS_OVLFLAG, OFS_OWFLAG,
		OFS_INTR, OFS_INTR};
	localparam int CLS_BIT [6] = '{0, FO_CL, FO_OVL, 4, IB_COMM, IB_SUPPLY};
	localparam int CLS_MB [6] = '{MB_OPENWIRE, MB_CURR_LIMIT, MB_THERMAL, MB_ABOVE_SUPPLY,
		MB_COMM_ERR, MB_SUPPLY_ERR};
	localparam logic [3:0] CLS_FRM [6] = '{4'h9, 4'ha, 4'hc, 4'h8, 4'h8, 4'h8};
	// pin table: {expected switch, data, enable, sync}
	localparam logic [9:0] PIN_TAB [5] = '{10'h157, 10'h03e, 10'h03d, 10'h003, 10'h3ff};

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic core_clk = 1'b0;
	logic rst_n = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, dat_o;
	logic [3:0] ev_ow = 4'h0, ev_cl = 4'h0, ev_th = 4'h0, ev_as = 4'h0;
	logic ev_comm = 1'b0, ev_sup = 1'b0;
	logic ser_req = 1'b1, en_req = 1'b0, sync_req = 1'b0;
	logic [3:0] data_req = 4'h0, chan_data, sw_on, gate_on;
	logic ack, ser_ctrl, en_in, sync_in, f_ow, f_oc, f_th, f_gl, fault_o, fault_oe_n, fault_line;
	int err_count = 0, checks_done = 0, cycles = 0;

	// 250 MHz core clock
	always #2 core_clk = ~core_clk;

	// ------------------------------------------------------------
	// design and host model
	// ------------------------------------------------------------
	fpm_top uut (.CORE_CLK(core_clk), .RST_N(rst_n), .CE(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
		.WB_ACK_O(ack), .SER_CTRL(ser_ctrl), .CHANNEL_DATA(chan_data), .ENABLE_IN(en_in),
		.SYNC_UPDATE_INPUT(sync_in), .EV_OPENWIRE(ev_ow), .EV_CURR_LIMIT(ev_cl),
		.EV_THERMAL(ev_th), .EV_ABOVE_SUPPLY(ev_as), .EV_COMM_ERR(ev_comm),
		.EV_SUPPLY_ERR(ev_sup), .CHANNEL_SWITCH_ON(sw_on), .GATE_DRIVE_ON(gate_on),
		.FRAME_OPENWIRE_STATUS(f_ow), .FRAME_OVERCURRENT_STATUS(f_oc),
		.FRAME_THERMAL_STATUS(f_th), .FRAME_GLOBAL_FAULT(f_gl), .FAULT_O(fault_o),
		.FAULT_OE_N(fault_oe_n));
	fpm_host_model host (.clk(core_clk), .rst_n(rst_n), .ser_req(ser_req), .data_req(data_req),
		.en_req(en_req), .sync_req(sync_req), .fault_o(fault_o), .fault_oe_n(fault_oe_n),
		.ser_ctrl(ser_ctrl), .chan_data(chan_data), .enable_in(en_in), .sync_in(sync_in),
		.fault_line(fault_line));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic close_out();
		if (err_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_pin(input logic [3:0] got, input logic [3:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// classic cycle: held until ack is seen high at a rising edge, then released
	task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// ack and read data are taken at the rising edge that sees ack high
		do begin
			@(posedge core_clk);
		end while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb_cycle(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		wb_cycle(1'b0, a, 32'h0);
		cmp_reg(rdat, exp);
	endtask

	// let n edges pass, then look between edges
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask

	// one-cycle fault event of class c on channel ch
	task automatic fire(input int c, input int ch);
		@(posedge core_clk);
		case (c)
			0: ev_ow[ch] <= 1'b1;
			1: ev_cl[ch] <= 1'b1;
			2: ev_th[ch] <= 1'b1;
			3: ev_as[ch] <= 1'b1;
			4: ev_comm <= 1'b1;
			default: ev_sup <= 1'b1;
		endcase
		@(posedge core_clk);
		{ev_ow, ev_cl, ev_th, ev_as, ev_comm, ev_sup} <= '0;
	endtask

	// masked or unmasked fault: pin, flag register, frame bits, then clear and release
	task automatic chk_fault(input int c, input int ch, input logic masked);
		int b;
		b = (c < 4) ? CLS_BIT[c] + ch : CLS_BIT[c];
		wr(OFS_MASK, masked ? (32'h1 << CLS_MB[c]) : 32'h0);
		fire(c, ch);
		wait_cyc(1);
		cmp_pin({3'b000, fault_line}, {3'b000, masked});
		rd(CLS_OFS[c], 32'h1 << b); // flag set whatever the mask
		cmp_pin({f_gl, f_th, f_oc, f_ow}, CLS_FRM[c]); // frame bits whatever the mask
		rd(OFS_STATUS, {27'h0, !masked, CLS_FRM[c]});
		wr(CLS_OFS[c], 32'h1 << b);
		wait_cyc(1);
		cmp_pin({3'b000, fault_line}, 4'h1);
		cmp_pin({f_gl, f_th, f_oc, f_ow}, 4'h0);
	endtask

	// ------------------------------------------------------------
	// timeout
	// ------------------------------------------------------------
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			close_out();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		// falling reset edge at time zero so every register resets at once
		rst_n <= 1'b0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		cmp_pin(sw_on, 4'h0);
		cmp_pin({3'b000, fault_oe_n}, 4'h1);
		// reset values, unmapped offset last
		for (int i = 0; i < 9; i++) begin
			rd(RST_OFS[i], RST_VAL[i]);
		end
		// pin control in default high-side mode
		for (int i = 0; i < 5; i++) begin
			@(posedge core_clk);
			ser_req <= 1'b0;
			{data_req, en_req, sync_req} <= PIN_TAB[i][5:0];
			wait_cyc(2);
			cmp_pin(sw_on, PIN_TAB[i][9:6]);
		end
		@(posedge core_clk);
		{ser_req, en_req, sync_req, data_req} <= 7'h40;
		// serial mode: switches follow the output register
		wr(OFS_OUTSET, 32'h5);
		wait_cyc(1);
		cmp_pin(sw_on, 4'h5);
		wr(OFS_OUTSET, 32'h0);
		// gate drive per mode: output modes on, input modes off
		wr(OFS_OWEN, 32'hf0);
		for (int m = 0; m < 4; m++) begin
			wr(OFS_MODE, {24'h0, {4{m[1:0]}}});
			wait_cyc(1);
			cmp_pin(gate_on, m[1] ? 4'h0 : 4'hf);
		end
		wr(OFS_MODE, 32'h0);
		// open wire with detection off: no flag, no pin
		wr(OFS_OWEN, 32'h0);
		fire(0, 3);
		wait_cyc(1);
		cmp_pin({3'b000, fault_line}, 4'h1);
		rd(OFS_OWFLAG, 32'h0);
		wr(OFS_OWEN, 32'h0f);
		// every fault class, unmasked then masked
		for (int c = 0; c < 6; c++) begin
			chk_fault(c, c % 4, 1'b0);
			chk_fault(c, c % 4, 1'b1);
		end
		// two faults: pin stays until the last one is cleared
		wr(OFS_MASK, 32'h0);
		fire(1, 1);
		fire(2, 2);
		wr(OFS_OVLFLAG, 32'h1 << (FO_CL + 1));
		wait_cyc(1);
		cmp_pin({3'b000, fault_line}, 4'h0);
		wr(OFS_OVLFLAG, 32'h1 << (FO_OVL + 2));
		wait_cyc(1);
		cmp_pin({3'b000, fault_line}, 4'h1);
		close_out();
	end
endmodule
`default_nettype wire
